// [common/isbe_regs.svh]
// Notes on behaviour
// - increment-skip adds one; destination bit 0 writes accumulator, 1 writes register
// - nonzero increment result completes in one cycle, next instruction runs normally
// - zero result discards fetched next word, idles instead, two cycles total
// - skip leaves pc two words past instruction, else one word past
// - increment-skip: decode, read, compute, write across the four phases
// - the skip's extra cycle changes no register, flag or memory
// - jump loads eleven-bit immediate into pc 10..0, upper bits from latch 4..3
// - jump takes two cycles, second idle while pipeline refills
`ifndef ISBE_REGS_SVH
`define ISBE_REGS_SVH
`define OPC_INC_SKIP   6'h0F
`define OPC_JUMP_TOP   3'h5
`define OPC_OR_LIT     6'h38
`define INSN_W         14
`define PC_W           13
`define DEST_BIT       7
`define FILE_ADDR_W    7
`define PC_RESET       13'h0000
`define ACC_RESET      8'h00
`endif

// [common/isbe_pkg.sv]
package isbe_pkg;
  typedef logic [13:0] insn_t;
  typedef logic [12:0] pc_t;
  typedef logic [7:0]  byte_t;
  typedef logic [6:0]  faddr_t;
  typedef enum logic [1:0] {
    phase_one,
    phase_two,
    phase_three,
    phase_four
  } phase_e;
endpackage

// [hw/isbe_phase_gen.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// quarter phase sequencer
// ****************************************
module isbe_phase_gen (
  input  wire logic            mclk_in,   // core clock
  input  wire logic            rst_in,    // async reset
  output isbe_pkg::phase_e     phase_out  // current quarter phase
);
  import isbe_pkg::*;
  phase_e phase_reg;
  phase_e phase_next;
  assign phase_next = phase_e'(2'(phase_reg) + 2'h1);
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= phase_one;
    end else begin
      phase_reg <= phase_next;
    end
  end
  assign phase_out = phase_reg;
endmodule
`default_nettype wire

// [hw/isbe_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "isbe_regs.svh"
module isbe_core (
  input  wire logic           mclk_in,       // core clock
  input  wire logic           rst_in,        // async reset
  input  wire isbe_pkg::insn_t insn_in,      // fetched instruction word
  output isbe_pkg::pc_t       fetch_addr_out,// program memory address
  input  wire isbe_pkg::byte_t file_rdata_in,// file register read data
  output isbe_pkg::faddr_t    file_addr_out, // file register address
  output isbe_pkg::byte_t     file_wdata_out,// file register write data
  output logic                file_we_out,   // file write strobe
  input  wire isbe_pkg::byte_t pc_high_latch_in, // high latch register
  output isbe_pkg::byte_t     acc_out,       // accumulator
  output logic                zero_flag_out, // zero flag
  output logic                idle_out       // core idling this cycle
);
  import isbe_pkg::*;

  // ****************************************
  // state
  // ****************************************
  phase_e phase;
  insn_t  ir_reg;
  pc_t    pc_reg;
  pc_t    pc_next;
  byte_t  acc_reg;
  byte_t  acc_next;
  logic   zero_reg;
  logic   zero_next;
  logic   idle_reg;
  logic   idle_next;
  byte_t  operand_reg;
  byte_t  result_reg;
  byte_t  result_next;
  faddr_t faddr_reg;
  byte_t  wdata_reg;
  logic   we_reg;
  logic   we_next;

  isbe_phase_gen u_isbe_phase_gen (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .phase_out (phase)
  );

  // ****************************************
  // decode
  // ****************************************
  function automatic logic is_inc_skip(input insn_t w);
    is_inc_skip = (w[13:8] == `OPC_INC_SKIP);
  endfunction
  function automatic logic is_jump(input insn_t w);
    is_jump = (w[13:11] == `OPC_JUMP_TOP);
  endfunction
  function automatic logic is_or_lit(input insn_t w);
    is_or_lit = (w[13:8] == `OPC_OR_LIT);
  endfunction

  wire logic  dec_inc  = is_inc_skip(ir_reg) & ~idle_reg;
  wire logic  dec_jump = is_jump(ir_reg) & ~idle_reg;
  wire logic  dec_or   = is_or_lit(ir_reg) & ~idle_reg;
  wire logic  dest_reg = ir_reg[`DEST_BIT];
  wire byte_t inc_sum  = byte_t'(operand_reg + 8'h01);
  wire byte_t or_val   = acc_reg | ir_reg[7:0];
  wire pc_t   jump_pc  = {pc_high_latch_in[4:3], ir_reg[10:0]};
  // the skip decision uses the phase-three sum, one phase before it commits
  wire logic  skip_hit = dec_inc & (result_reg == 8'h00);

  // phase three computes, phase four commits
  assign result_next = (phase == phase_three) ? (dec_inc ? inc_sum : or_val) : result_reg;

  assign acc_next  = (phase == phase_four && dec_inc && !dest_reg) ? result_reg :
                     (phase == phase_four && dec_or) ? result_reg : acc_reg;
  assign we_next   = (phase == phase_three) && dec_inc && dest_reg;
  // zero flag, increment-skip leaves flags alone
  assign zero_next = (phase == phase_four && dec_or) ? (result_reg == 8'h00) : zero_reg;

  // discard prefetched word, idle next cycle
  assign idle_next = (phase == phase_four) ? (skip_hit | dec_jump) : idle_reg;

  // pc is the fetch pointer, a word ahead; a skip lets it run on rather than rewind
  // pc update at phase four
  assign pc_next   = (phase != phase_four) ? pc_reg :
                     dec_jump ? jump_pc : pc_t'(pc_reg + 13'h0001);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_reg      <= 14'h0000;
      pc_reg      <= `PC_RESET;
      acc_reg     <= `ACC_RESET;
      zero_reg    <= 1'b0;
      idle_reg    <= 1'b1;
      operand_reg <= 8'h00;
      result_reg  <= 8'h00;
      faddr_reg   <= 7'h00;
      wdata_reg   <= 8'h00;
      we_reg      <= 1'b0;
    end else begin
      // file data comes from logic on this clock, so it is read without a synchroniser
      // phase two reads the file register
      if (phase == phase_two) begin
        operand_reg <= file_rdata_in;
      end
      // word latched here is decoded through phase one
      if (phase == phase_four) begin
        ir_reg <= insn_in;
        faddr_reg <= insn_in[6:0];
      end
      result_reg <= result_next;
      acc_reg    <= acc_next;
      zero_reg   <= zero_next;
      idle_reg   <= idle_next;
      pc_reg     <= pc_next;
      we_reg     <= we_next;
      if (we_next) begin
        wdata_reg <= inc_sum;
      end
    end
  end

  assign fetch_addr_out = pc_reg;
  assign file_addr_out  = faddr_reg;
  assign file_wdata_out = wdata_reg;
  assign file_we_out    = we_reg;
  assign acc_out        = acc_reg;
  assign zero_flag_out  = zero_reg;
  assign idle_out       = idle_reg;

  // ****************************************
  // checks
  // ****************************************
  // no writes while idle
  idle_no_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    idle_reg |-> !we_reg)
    else $error("write during idle cycle");
  idle_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    idle_reg |=> $stable(acc_reg) && $stable(zero_reg))
    else $error("register changed during idle cycle");
  // register write only in phase four
  write_phase_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    we_reg |-> phase == phase_four)
    else $error("file write outside phase four");
  // pc steps by one per cycle unless jumping
  pc_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && !dec_jump) |=> pc_reg == pc_t'($past(pc_reg) + 13'h0001))
    else $error("pc did not advance by one");
  jump_target_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_jump) |=> pc_reg == $past(jump_pc))
    else $error("jump target wrong");
  jump_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_jump) |=> idle_reg [*4])
    else $error("jump not followed by idle");
  skip_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && skip_hit) |=> idle_reg)
    else $error("skip not taken");
  no_skip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_inc && result_reg != 8'h00) |=> !idle_reg)
    else $error("spurious skip");
  or_result_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_three && dec_or) |=> ##1 acc_reg == $past(or_val, 2) && zero_reg == ($past(or_val, 2) == 8'h00))
    else $error("or literal result wrong");
  inc_acc_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_inc && !dest_reg) |=> acc_reg == $past(result_reg))
    else $error("increment to accumulator wrong");

  // ****************************************
  // skip, idle, increment and phase checks
  // ****************************************
  // skip lands two past
  skip_pc_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && skip_hit) |=> ##4 pc_reg == pc_t'($past(pc_reg, 5) + 13'h0002))
    else $error("pc after skip wrong");
  skip_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && skip_hit) |=> (!we_reg) [*4])
    else $error("file write in skip cycle");
  jump_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_jump) |=> (!we_reg) [*4])
    else $error("file write in jump idle cycle");
  inc_file_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_three && dec_inc && dest_reg) |=> we_reg && wdata_reg == $past(inc_sum))
    else $error("increment to file wrong");
  inc_no_file_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_three && dec_inc && !dest_reg) |=> !we_reg)
    else $error("file written for accumulator destination");
  inc_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && dec_inc) |=> $stable(zero_reg))
    else $error("increment changed zero flag");
  operand_read_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_two) |=> operand_reg == $past(file_rdata_in))
    else $error("operand not read in phase two");
  compute_phase_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_three && dec_inc) |=> result_reg == $past(inc_sum))
    else $error("sum not formed in phase three");
  phase_rotate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four) |=> phase == phase_one)
    else $error("phase did not wrap to phase one");
  idle_once_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (phase == phase_four && idle_reg) |=> !idle_reg)
    else $error("idle lasted more than one cycle");
endmodule
`default_nettype wire

// [verification/isbe_prog_mem.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// program memory model
// ****************************************
module isbe_prog_mem (
  input  wire isbe_pkg::pc_t  addr_in,  // fetch address
  output isbe_pkg::insn_t     word_out  // fetched word
);
  import isbe_pkg::*;
  insn_t words [0:15];
  // bits 12:11 pick a page and every page sees the same sixteen words;
  // words above them read as zero, which the core runs as a no-op without idling
  assign word_out = (addr_in[10:4] == 7'h00) ? words[addr_in[3:0]] : 14'h0000;
endmodule
`default_nettype wire

// [verification/tb_isbe_core.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_isbe_core;
  import isbe_pkg::*;
  logic mclk_in = 1'b0, rst_in = 1'b1, file_we_out, zero_flag_out, idle_out;
  insn_t insn_in;
  pc_t fetch_addr_out;
  byte_t file_rdata_in = 8'h00, file_wdata_out, pc_high_latch_in = 8'h00, acc_out, r, hl;
  faddr_t file_addr_out;
  byte_t fdata [0:127];
  logic [14:0] fexp [$];
  logic [8:0] aexp [$], prev;
  pc_t pexp [$];
  logic prev_idle = 1'b1;
  logic [7:0] idle_len = 8'h00;
  int miscompares = 0, checked = 0;
  isbe_prog_mem u_isbe_prog_mem (.addr_in(fetch_addr_out), .word_out(insn_in));
  isbe_core u_isbe_core (.mclk_in(mclk_in), .rst_in(rst_in), .insn_in(insn_in),
    .fetch_addr_out(fetch_addr_out), .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out),
    .file_wdata_out(file_wdata_out), .file_we_out(file_we_out), .pc_high_latch_in(pc_high_latch_in),
    .acc_out(acc_out), .zero_flag_out(zero_flag_out), .idle_out(idle_out));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) file_rdata_in <= fdata[file_addr_out];
  task automatic cmp_write(input logic [14:0] exp, input logic [14:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] file write expected %h seen %h", exp, got);
    end
  endtask
  task automatic cmp_acc(input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] zero and acc expected %h seen %h", exp, got);
    end
  endtask
  task automatic cmp_pc(input pc_t exp, input pc_t got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] fetch address at idle expected %h seen %h", exp, got);
    end
  endtask
  task automatic cmp_span(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] idle span expected %h seen %h", exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (fexp.size() != 0 || aexp.size() != 0 || pexp.size() != 0) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // results are looked at mid-cycle, clear of the edge that makes them
  initial begin
    @(negedge rst_in);
    prev = 9'h000;
    prev_idle = 1'b1;
    idle_len = 8'h00;
    forever begin
      @(negedge mclk_in);
      if (file_we_out === 1'b1 && fexp.size() > 0) begin
        cmp_write(fexp.pop_front(), {file_addr_out, file_wdata_out});
      end else if (file_we_out === 1'b1) begin
        cmp_write(15'h7FFF, {file_addr_out, file_wdata_out});
      end
      if ({zero_flag_out, acc_out} !== prev) begin
        prev = {zero_flag_out, acc_out};
        cmp_acc((aexp.size() > 0) ? aexp.pop_front() : 9'h1FF, prev);
      end
      // an idle cycle starts only after a skip or a jump, and the fetch pointer shows where it lands
      if (idle_out === 1'b1 && prev_idle !== 1'b1) begin
        cmp_pc((pexp.size() > 0) ? pexp.pop_front() : 13'h1FFF, fetch_addr_out);
      end
      if (idle_out === 1'b1) begin
        idle_len = idle_len + 8'h01;
      end else if (prev_idle === 1'b1) begin
        cmp_span(8'h04, idle_len);
        idle_len = 8'h00;
      end
      prev_idle = idle_out;
    end
  end
  initial begin
    #(2000 * 50);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h2C13));
    foreach (fdata[i]) fdata[i] = 8'h00;
    foreach (u_isbe_prog_mem.words[i]) u_isbe_prog_mem.words[i] = 14'h0000;
    // bit 6 and bit 0 of r kept clear so r+1 never carries and the later or is visible
    r = (8'($urandom) & 8'hBE) | 8'h80;
    fdata[16] = 8'h41;
    fdata[17] = 8'hFF;
    fdata[18] = r;
    u_isbe_prog_mem.words[0] = 14'h0F90;
    u_isbe_prog_mem.words[1] = 14'h3835;
    u_isbe_prog_mem.words[2] = 14'h0F91;
    u_isbe_prog_mem.words[3] = 14'h38FF;
    u_isbe_prog_mem.words[4] = 14'h0F12;
    u_isbe_prog_mem.words[5] = 14'h280A;
    u_isbe_prog_mem.words[10] = 14'h3840;
    // the skipped word 3 and the word after the jump must leave no trace
    fexp = '{15'h1042, 15'h1100};
    aexp = '{9'h035, {1'b0, r + 8'h01}, {1'b0, (r + 8'h01) | 8'h40}};
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    hl = 8'($urandom);
    pc_high_latch_in <= hl;
    // skip lands two past word 2; the jump lands on word 10 of the page the latch picks
    pexp = '{13'h0004, {hl[4:3], 11'h00A}};
    repeat (60) @(posedge mclk_in);
    $display("test program done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
